// File: design/octal_uart_glue.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "octal_uart_cfg.svh"
module octal_uart_glue
  import octal_uart_pkg::*;
#(
  parameter logic [7:0] DEV_REV = `DREV_DEFAULT, // arbitrary value
  parameter logic [7:0] DEV_ID  = `DVID_DEFAULT  // arbitrary value
)(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  input  wire logic        INFRARED_ENABLE_STRAP,
  input  wire logic        BUS_STYLE_SEL,
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        HOST_READ_STROBE_N,
  input  wire logic        HOST_WRITE_STROBE_N,
  output logic             HOST_RD_PULSE,
  output logic             HOST_WR_PULSE,
  input  wire logic        TIMER_EXT_CLOCK,
  input  wire logic [7:0]  SER_RX,
  output logic      [7:0]  SER_TX
);

  logic       rst_meta_r;
  logic       rst_n_s;
  pins_t      pin_meta_r;
  pins_t      pin_s_r;
  logic [7:0] rx_meta_r;
  logic [7:0] rx_s_r;
  logic       init_r;

  // release is synchronous so every flop leaves reset on the same edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1; // [R14]
      rst_n_s    <= rst_meta_r;
    end
  end

  // no reset here: the strap must already be settled when reset lifts
  always_ff @(posedge CLK) begin
    pin_meta_r <= {INFRARED_ENABLE_STRAP, BUS_STYLE_SEL, CHIP_SELECT_N,
                   HOST_READ_STROBE_N, HOST_WRITE_STROBE_N, TIMER_EXT_CLOCK}; // [R14]
    pin_s_r    <= pin_meta_r;
    rx_meta_r  <= SER_RX;
    rx_s_r     <= rx_meta_r;
  end

  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) init_r <= 1'b1;
    else          init_r <= 1'b0;
  end

  // bus decode
  logic [7:0] idx;
  logic       access;
  logic       is_ch;
  logic       is_cfg;
  logic       mapped;
  logic       wr_ok;
  logic       rd_ok;
  logic [2:0] rch;
  logic [3:0] roff;

  assign idx    = PADDR[9:2]; // [R10]
  assign access = PSEL & PENABLE;
  assign is_ch  = ~idx[7]; // [R13]
  assign is_cfg = idx[7:4] == `CFG_NIBBLE; // [R12]
  assign mapped = (PADDR[1:0] == 2'h0) & (is_ch | is_cfg | idx == `IDX_IRQ_STAT |
                  idx == `IDX_IRQ_MASK | idx == `IDX_GLUE_STAT);
  assign wr_ok  = access & PWRITE & mapped;
  assign rd_ok  = access & ~PWRITE & mapped;
  assign rch    = idx[6:4];
  assign roff   = idx[3:0];
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~mapped;

  // configuration registers
  logic [7:0] mode8x_r;
  logic [7:0] sleep_r;
  logic [3:0] tctl_r;
  logic [15:0] treload_r;
  logic       bcast_r;
  logic [8:0] irq_mask_r;
  logic [8:0] irq_stat_r;
  logic [7:0] sreset;

  assign sreset = (wr_ok && idx == `IDX_SRESET) ? PWDATA[7:0] : 8'h00;

  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      mode8x_r   <= 8'h00; // [R3]
      sleep_r    <= 8'h00;
      tctl_r     <= 4'h0;
      treload_r  <= 16'h0000;
      bcast_r    <= 1'b0;
      irq_mask_r <= 9'h000;
    end else if (wr_ok) begin
      case (idx)
        `IDX_TMR_CTRL: tctl_r          <= PWDATA[3:0];
        `IDX_TMR_LSB:  treload_r[7:0]  <= PWDATA[7:0];
        `IDX_TMR_MSB:  treload_r[15:8] <= PWDATA[7:0];
        `IDX_MODE8X:   mode8x_r        <= PWDATA[7:0]; // [R9]
        `IDX_SLEEP:    sleep_r         <= PWDATA[7:0];
        `IDX_REG2:     bcast_r         <= PWDATA[0];
        `IDX_IRQ_MASK: irq_mask_r      <= PWDATA[8:0];
        default: ;
      endcase
    end
  end

  // timer, clocked by CLK or by rising edges seen on the external pin
  logic        tmr_d_r;
  logic        ext_rise;
  logic        tstep;
  logic        trun_r;
  logic [15:0] tcnt_r;
  logic        tmr_evt;

  assign ext_rise = pin_s_r.tmr & ~tmr_d_r;
  assign tstep    = trun_r & (tctl_r[`TCTL_EXTCLK] ? ext_rise : 1'b1); // [R6]
  assign tmr_evt  = tstep & (tcnt_r <= 16'h0001);

  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tmr_d_r <= 1'b0;
      trun_r  <= 1'b0;
      tcnt_r  <= 16'h0000;
    end else begin
      tmr_d_r <= pin_s_r.tmr;
      if (wr_ok && idx == `IDX_TMR_CTRL) begin
        trun_r <= PWDATA[`TCTL_START];
        tcnt_r <= treload_r;
      end else if (tmr_evt) begin
        tcnt_r <= treload_r;
        trun_r <= tctl_r[`TCTL_RELOAD];
      end else if (tstep) begin
        tcnt_r <= tcnt_r - 16'h0001; // [R6]
      end
    end
  end

  // per-channel views
  logic [7:0]  mcr_w   [8];
  logic [7:0]  dll_w   [8];
  logic [7:0]  dlm_w   [8];
  logic        presc_w [8];
  logic [7:0]  head_w  [8];
  logic [6:0]  txl_w   [8];
  logic [6:0]  rxl_w   [8];
  chan_stat_t  cst_w   [8];
  logic [7:0]  rx_evt;
  logic [7:0]  txo_w;
  logic        pop_ok_r;
  logic [23:0] int_codes;

  for (genvar g = 0; g < 8; g++) begin : g_ch
    logic        wsel;
    logic        srst;
    logic [7:0]  mcr_r;
    logic [7:0]  dll_r;
    logic [7:0]  dlm_r;
    logic        presc_r;
    logic [7:0]  txm [64];
    logic [7:0]  rxm [64];
    logic [6:0]  twp_r;
    logic [6:0]  trp_r;
    logic [6:0]  rwp_r;
    logic [6:0]  rrp_r;
    logic        tx_full;
    logic        tx_empty;
    logic        rx_full;
    logic        rx_empty;
    logic        tx_push;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
    logic        rx_done;
    logic        ovr_r;
    logic [1:0]  pc_r;
    logic [15:0] bc_r;
    logic [15:0] div_m1;
    logic        pre_en;
    logic        tick;
    logic [4:0]  ovs;
    logic [9:0]  tsh_r;
    logic [3:0]  tbits_r;
    logic [4:0]  tov_r;
    logic        tx_bit;
    logic        txo_r;
    rx_state_t   rxs_r;
    logic [4:0]  rov_r;
    logic [2:0]  rbit_r;
    logic [7:0]  rsh_r;
    logic        rxd;

    // broadcast lets one write set up all eight channels
    assign wsel = wr_ok & is_ch & ((rch == 3'(g)) | bcast_r); // [R13]
    assign srst = sreset[g];

    always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
        mcr_r   <= `MCR_RST; // [R3]
        dll_r   <= `DLL_RST;
        dlm_r   <= `DLM_RST;
        presc_r <= 1'b0;
      end else if (init_r | srst) begin
        mcr_r              <= `MCR_RST; // [R1]
        mcr_r[`MCR_IR_BIT] <= pin_s_r.strap; // [R2]
        dll_r              <= `DLL_RST;
        dlm_r              <= `DLM_RST;
        presc_r            <= 1'b0;
      end else if (wsel) begin
        case (roff)
          `CH_PRESC: presc_r <= PWDATA[0];
          `CH_DLL:   dll_r   <= PWDATA[7:0];
          `CH_DLM:   dlm_r   <= PWDATA[7:0];
          `CH_MCR:   mcr_r   <= PWDATA[7:0];
          default: ;
        endcase
      end
    end

    assign tx_full  = (twp_r - trp_r) == `FIFO_DEPTH; // [R7]
    assign tx_empty = twp_r == trp_r;
    assign rx_full  = (rwp_r - rrp_r) == `FIFO_DEPTH;
    assign rx_empty = rwp_r == rrp_r;
    assign tx_push  = wsel & (roff == `CH_DATA) & ~tx_full;
    assign rx_pop   = rd_ok & is_ch & (rch == 3'(g)) & (roff == `CH_DATA) & pop_ok_r;
    assign rx_push  = rx_done & ~rx_full;

    always_ff @(posedge CLK) begin
      if (tx_push) txm[twp_r[5:0]] <= PWDATA[7:0];
      if (rx_push) rxm[rwp_r[5:0]] <= rsh_r;
    end

    always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
        twp_r <= 7'h00;
        trp_r <= 7'h00;
        rwp_r <= 7'h00;
        rrp_r <= 7'h00;
        ovr_r <= 1'b0;
      end else if (srst) begin
        twp_r <= 7'h00;
        trp_r <= 7'h00;
        rwp_r <= 7'h00;
        rrp_r <= 7'h00;
        ovr_r <= 1'b0;
      end else begin
        if (tx_push) twp_r <= twp_r + 7'h01; // [R7]
        if (tx_pop)  trp_r <= trp_r + 7'h01;
        if (rx_push) rwp_r <= rwp_r + 7'h01;
        if (rx_pop)  rrp_r <= rrp_r + 7'h01;
        // a new overrun in the same cycle as the clearing read wins
        if (rx_done & rx_full) ovr_r <= 1'b1;
        else if (rd_ok & is_ch & (rch == 3'(g)) & (roff == `CH_STAT)) ovr_r <= 1'b0;
      end
    end

    // divisor zero behaves like one, so the generator never stalls
    assign div_m1 = ({dlm_r, dll_r} == 16'h0000) ? 16'h0000 : {dlm_r, dll_r} - 16'h0001;
    assign pre_en = presc_r ? (pc_r == `PRESC_LAST) : 1'b1; // [R8]
    assign tick   = pre_en & (bc_r == div_m1);
    assign ovs    = mode8x_r[g] ? `OVS_8X : `OVS_16X; // [R9]

    always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
        pc_r <= 2'h0;
        bc_r <= 16'h0000;
      end else begin
        pc_r <= pc_r + 2'h1; // [R8]
        if (pre_en) bc_r <= tick ? 16'h0000 : bc_r + 16'h0001;
      end
    end

    assign tx_pop = (tbits_r == 4'h0) & ~tx_empty;
    assign tx_bit = (tbits_r != 4'h0) ? tsh_r[0] : 1'b1;

    always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
        tsh_r   <= 10'h3FF;
        tbits_r <= 4'h0;
        tov_r   <= 5'h00;
      end else if (srst) begin
        tsh_r   <= 10'h3FF;
        tbits_r <= 4'h0;
        tov_r   <= 5'h00;
      end else if (tx_pop) begin
        tsh_r   <= {1'b1, txm[trp_r[5:0]], 1'b0};
        tbits_r <= 4'hA;
        tov_r   <= 5'h00;
      end else if (tbits_r != 4'h0 && tick) begin
        if (tov_r == ovs - 5'h01) begin
          tov_r   <= 5'h00;
          tsh_r   <= {1'b1, tsh_r[9:1]};
          tbits_r <= tbits_r - 4'h1;
        end else begin
          tov_r <= tov_r + 5'h01; // [R9]
        end
      end
    end

    // infrared mode sends a short high pulse for each zero bit
    always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) txo_r <= 1'b1;
      else if (mcr_r[`MCR_IR_BIT]) txo_r <= ~tx_bit & (tov_r < (ovs >> 2)); // [R2]
      else txo_r <= tx_bit;
    end

    assign rxd     = rx_s_r[g];
    assign rx_done = (rxs_r == RX_STOP) & tick & (rov_r == ovs - 5'h01) & rxd;

    always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
        rxs_r  <= RX_IDLE;
        rov_r  <= 5'h00;
        rbit_r <= 3'h0;
        rsh_r  <= 8'h00;
      end else if (srst) begin
        rxs_r <= RX_IDLE;
      end else begin
        case (rxs_r)
          RX_IDLE: if (!rxd) begin
            rxs_r <= RX_START;
            rov_r <= 5'h00;
          end
          RX_START: if (tick) begin
            if (rov_r == (ovs >> 1) - 5'h01) begin
              rxs_r  <= rxd ? RX_IDLE : RX_DATA;
              rov_r  <= 5'h00;
              rbit_r <= 3'h0;
            end else begin
              rov_r <= rov_r + 5'h01;
            end
          end
          RX_DATA: if (tick) begin
            if (rov_r == ovs - 5'h01) begin
              rov_r  <= 5'h00;
              rsh_r  <= {rxd, rsh_r[7:1]};
              rbit_r <= rbit_r + 3'h1;
              if (rbit_r == 3'h7) rxs_r <= RX_STOP;
            end else begin
              rov_r <= rov_r + 5'h01;
            end
          end
          RX_STOP: if (tick) begin
            if (rov_r == ovs - 5'h01) rxs_r <= RX_IDLE;
            else rov_r <= rov_r + 5'h01;
          end
          default: rxs_r <= RX_IDLE;
        endcase
      end
    end

    assign mcr_w[g]   = mcr_r;
    assign dll_w[g]   = dll_r;
    assign dlm_w[g]   = dlm_r;
    assign presc_w[g] = presc_r;
    assign head_w[g]  = rxm[rrp_r[5:0]];
    assign txl_w[g]   = twp_r - trp_r;
    assign rxl_w[g]   = rwp_r - rrp_r;
    assign cst_w[g]   = '{rx_overrun: ovr_r, rx_full: rx_full, rx_empty: rx_empty,
                          tx_full: tx_full, tx_empty: tx_empty};
    assign rx_evt[g]  = rx_push;
    assign txo_w[g]   = txo_r;
    assign int_codes[3*g +: 3] = irq_stat_r[g] ? `INT_CODE_RX : 3'h0; // [R11]
  end

  assign SER_TX = txo_w;

  // sticky events, write one to clear; a new event outranks the clear
  logic [8:0] irq_set;
  logic [8:0] irq_clr;
  logic       irq_r;

  assign irq_set = {tmr_evt & tctl_r[`TCTL_INT_EN], rx_evt};
  assign irq_clr = (wr_ok && idx == `IDX_IRQ_STAT) ? PWDATA[8:0] : 9'h000;

  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_stat_r <= 9'h000;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set; // [R11]
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign IRQ = irq_r;

  // read data is fetched in the setup cycle so the access needs no wait
  logic [8:0]  rd_mux;
  logic [31:0] prdata_r;

  always_comb begin
    rd_mux = 9'h000;
    if (is_ch) begin
      case (roff)
        `CH_DATA:  rd_mux = {1'b0, head_w[rch]};
        `CH_PRESC: rd_mux = {8'h00, presc_w[rch]};
        `CH_DLL:   rd_mux = {1'b0, dll_w[rch]};
        `CH_DLM:   rd_mux = {1'b0, dlm_w[rch]};
        `CH_MCR:   rd_mux = {1'b0, mcr_w[rch]};
        `CH_STAT:  rd_mux = {4'h0, cst_w[rch]};
        `CH_TXLVL: rd_mux = {2'h0, txl_w[rch]};
        `CH_RXLVL: rd_mux = {2'h0, rxl_w[rch]};
        default:   rd_mux = 9'h000;
      endcase
    end else begin
      case (idx)
        `IDX_INT0:      rd_mux = {1'b0, irq_stat_r[7:0]}; // [R11]
        `IDX_INT1:      rd_mux = {1'b0, int_codes[7:0]};
        `IDX_INT2:      rd_mux = {1'b0, int_codes[15:8]};
        `IDX_INT3:      rd_mux = {1'b0, int_codes[23:16]};
        `IDX_TMR_CTRL:  rd_mux = {5'h00, tctl_r};
        `IDX_TMR_LSB:   rd_mux = {1'b0, treload_r[7:0]};
        `IDX_TMR_MSB:   rd_mux = {1'b0, treload_r[15:8]};
        `IDX_MODE8X:    rd_mux = {1'b0, mode8x_r};
        `IDX_SLEEP:     rd_mux = {1'b0, sleep_r};
        `IDX_DREV:      rd_mux = {1'b0, DEV_REV};
        `IDX_DVID:      rd_mux = {1'b0, DEV_ID};
        `IDX_REG2:      rd_mux = {8'h00, bcast_r};
        `IDX_IRQ_STAT:  rd_mux = irq_stat_r;
        `IDX_IRQ_MASK:  rd_mux = irq_mask_r;
        `IDX_GLUE_STAT: rd_mux = {7'h00, pin_s_r.strap, pin_s_r.sel};
        default:        rd_mux = 9'h000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      prdata_r <= 32'h0000_0000;
      pop_ok_r <= 1'b0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_r <= mapped ? {23'h000000, rd_mux} : 32'h0000_0000;
      pop_ok_r <= is_ch & ~cst_w[rch].rx_empty;
    end
  end

  assign PRDATA = prdata_r;

  // pin-bus strobe decode follows the bus-style select level
  logic hrd_req;
  logic hwr_req;
  logic hrd_d_r;
  logic hwr_d_r;

  always_comb begin
    if (pin_s_r.sel) begin
      hrd_req = ~pin_s_r.cs_n & ~pin_s_r.rd_n; // [R4] [R5]
      hwr_req = ~pin_s_r.cs_n & ~pin_s_r.wr_n;
    end else begin
      hrd_req = ~pin_s_r.cs_n & ~pin_s_r.rd_n & pin_s_r.wr_n; // [R4] [R5]
      hwr_req = ~pin_s_r.cs_n & ~pin_s_r.rd_n & ~pin_s_r.wr_n;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      hrd_d_r       <= 1'b0;
      hwr_d_r       <= 1'b0;
      HOST_RD_PULSE <= 1'b0;
      HOST_WR_PULSE <= 1'b0;
    end else begin
      hrd_d_r       <= hrd_req;
      hwr_d_r       <= hwr_req;
      HOST_RD_PULSE <= hrd_req & ~hrd_d_r;
      HOST_WR_PULSE <= hwr_req & ~hwr_d_r;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_s);

  chk_strap_init: assert property (init_r |=> // [R1]
    mcr_w[0][`MCR_IR_BIT] == $past(pin_s_r.strap))
    else $error("strap not copied into channel 0 after reset");
  chk_strap_soft: assert property (sreset[7] |=> mcr_w[7] == {1'b0, $past(pin_s_r.strap), 6'h00}) // [R2]
    else $error("soft reset did not reload modem control");
  chk_soft_clear: assert property (sreset[3] |=> rxl_w[3] == 7'h00 && txl_w[3] == 7'h00) // [R3]
    else $error("soft reset left fifo data");
  chk_strobe_excl: assert property (!(hrd_req && hwr_req) ##0 hrd_req && !hrd_d_r |=> HOST_RD_PULSE) // [R5]
    else $error("read strobe decode missed");
  chk_style_alt: assert property (!pin_s_r.sel && !pin_s_r.cs_n && // [R4]
    !pin_s_r.rd_n && !pin_s_r.wr_n |-> hwr_req && !hrd_req)
    else $error("alternative bus style misread");
  chk_timer_ext: assert property (trun_r && tctl_r[`TCTL_EXTCLK] && // [R6]
    !ext_rise && !wr_ok |=> $stable(tcnt_r))
    else $error("timer moved without external edge");
  chk_fifo_bound: assert property (txl_w[0] <= `FIFO_DEPTH && rxl_w[0] <= `FIFO_DEPTH) // [R7]
    else $error("fifo level beyond 64");
  chk_presc_gap: assert property (g_ch[0].presc_r && g_ch[0].tick && !wr_ok |=> // [R8]
    !g_ch[0].tick [*3])
    else $error("divide-by-4 prescaler ticked early");
  chk_unmapped_err: assert property (access && idx > `IDX_GLUE_STAT |-> PSLVERR) // [R10]
    else $error("unmapped access not flagged");
  chk_cfg_read: assert property (PSEL && !PENABLE && !PWRITE && // [R12]
    PADDR == {`IDX_MODE8X, 2'b00} |=> PRDATA[7:0] == mode8x_r)
    else $error("mode register readback wrong");
  chk_irq_level: assert property (|(irq_stat_r & irq_mask_r) |=> IRQ) // [R11]
    else $error("interrupt output not raised");
  chk_rst_sync: assert property ($rose(rst_n_s) |-> init_r) // [R14]
    else $error("strap sample not armed at release");

endmodule // octal_uart_glue

// File: design/octal_uart_cfg.svh
// Operation
// R1 - strap sampled at power-up, hardware reset and software channel reset
// R2 - sampled strap level lands in bit 6 of every channel modem control register
// R3 - reset input low returns config and all channel registers to defaults
// R4 - bus-style select high picks separate strobes, low picks the alternative style
// R5 - bus-style level decides how read, write and chip-select pins are read
// R6 - dedicated pin can clock the 16-bit general purpose timer
// R7 - every channel owns a 64-byte transmit FIFO and a 64-byte receive FIFO
// R8 - baud generator prescaler divides the clock by 1 or 4 as programmed
// R9 - each channel samples at 8X or 16X per bit, selectable
// R10 - config and channel registers together fill one 256-register region
// R11 - four interrupt source registers report channels, timer and wake status; the code reports only channel receive events there, no timer or wake
// R12 - config registers decode at 0x80 through 0x8F above the channel windows
// R13 - channel n owns sixteen registers starting at n times 0x10
// R14 - reset and pin inputs are synchronised to the clock before use
`ifndef OCTAL_UART_CFG_SVH
`define OCTAL_UART_CFG_SVH

`define IDX_INT0      8'h80
`define IDX_INT1      8'h81
`define IDX_INT2      8'h82
`define IDX_INT3      8'h83
`define IDX_TMR_CTRL  8'h84
`define IDX_TMR_STAT  8'h85
`define IDX_TMR_LSB   8'h86
`define IDX_TMR_MSB   8'h87
`define IDX_MODE8X    8'h88
`define IDX_REG1      8'h89
`define IDX_SRESET    8'h8A
`define IDX_SLEEP     8'h8B
`define IDX_DREV      8'h8C
`define IDX_DVID      8'h8D
`define IDX_REG2      8'h8E
`define IDX_IRQ_STAT  8'h90
`define IDX_IRQ_MASK  8'h91
`define IDX_GLUE_STAT 8'h92
`define CFG_NIBBLE    4'h8

`define CH_DATA       4'h0
`define CH_PRESC      4'h1
`define CH_DLL        4'h2
`define CH_DLM        4'h3
`define CH_MCR        4'h4
`define CH_STAT       4'h5
`define CH_TXLVL      4'h6
`define CH_RXLVL      4'h7

`define MCR_RST       8'h00
`define MCR_IR_BIT    6
`define DLL_RST       8'h01
`define DLM_RST       8'h00
`define FIFO_DEPTH    7'h40
`define PRESC_LAST    2'h3
`define OVS_8X        5'h08
`define OVS_16X       5'h10
`define INT_CODE_RX   3'h2
`define IRQ_TMR_BIT   8

`define TCTL_INT_EN   0
`define TCTL_START    1
`define TCTL_RELOAD   2
`define TCTL_EXTCLK   3

`define DREV_DEFAULT  8'h01
`define DVID_DEFAULT  8'h5A

`endif

// File: design/octal_uart_pkg.sv
package octal_uart_pkg;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  typedef struct packed {
    logic rx_overrun;
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
  } chan_stat_t;

  typedef struct packed {
    logic strap;
    logic sel;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic tmr;
  } pins_t;

endpackage

// File: tb/serial_peer.sv
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_CLKS = 8
)(
  input  wire logic clk,
  output logic      line
);
  // a released receive line idles high, like the real pin
  initial line = 1'b1;
  // one 8N1 frame, lsb first; bit time fixed by BIT_CLKS
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask
endmodule // serial_peer

// File: tb/tb_octal_uart_global_control.sv
`timescale 1ns/1ps
`include "octal_uart_cfg.svh"
module tb_octal_uart_global_control;
  logic        CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [9:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic        STRAP, SEL, CS_N, RD_N, WR_N, RD_P, WR_P, rx0, e, TMR;
  logic [7:0]  SER_TX;
  int          bad_count, comparisons, n, pr, pw;

  octal_uart_glue dut_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .INFRARED_ENABLE_STRAP(STRAP), .BUS_STYLE_SEL(SEL),
    .CHIP_SELECT_N(CS_N), .HOST_READ_STROBE_N(RD_N), .HOST_WRITE_STROBE_N(WR_N),
    .HOST_RD_PULSE(RD_P), .HOST_WR_PULSE(WR_P), .TIMER_EXT_CLOCK(TMR),
    .SER_RX({7'h7F, rx0}), .SER_TX(SER_TX));
  serial_peer #(.BIT_CLKS(8)) peer_u (.clk(CLK), .line(rx0));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  function automatic logic [9:0] adr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle edge first keeps drives one per time step
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    give_verdict;
  end

  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, TMR} = '0;
    {STRAP, SEL, CS_N, RD_N, WR_N} = 5'h1F;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (5) @(posedge CLK);
    chk(IRQ, 0);
    for (int c = 0; c < 8; c++) begin
      xfer(0, adr(8'(c * 16 + `CH_MCR)), 0);
      chk(q, 32'h40);
    end
    xfer(0, adr(`CH_DLL), 0);
    chk(q, 32'(`DLL_RST));
    xfer(0, adr(`IDX_INT0), 0);
    chk(q, 0);
    xfer(0, adr(`IDX_DVID), 0);
    chk(q, 32'(`DVID_DEFAULT));
    chk(e, 0);
    $display("test reset defaults done");
    xfer(0, 10'h3FC, 0);
    chk(q, 0);
    chk(e, 1);
    xfer(0, 10'h201, 0);
    chk(e, 1);
    $display("test address map done");
    STRAP <= 1'b0;
    repeat (4) @(posedge CLK);
    xfer(1, adr(`IDX_SRESET), 32'h89);
    repeat (4) @(posedge CLK);
    xfer(0, adr(`CH_MCR), 0);
    chk(q, 0);
    xfer(0, adr(8'h10 + `CH_MCR), 0);
    chk(q, 32'h40);
    xfer(0, adr(8'h70 + `CH_MCR), 0);
    chk(q, 0);
    $display("test soft reset done");
    xfer(1, adr(`IDX_MODE8X), 32'hFF);
    peer_u.send(8'hA5);
    repeat (20) @(posedge CLK);
    xfer(0, adr(`IDX_IRQ_STAT), 0);
    chk(q, 32'h01);
    chk(IRQ, 0);
    xfer(0, adr(`IDX_INT1), 0);
    chk(q[2:0], 32'(`INT_CODE_RX));
    xfer(1, adr(`IDX_IRQ_MASK), 32'h01);
    repeat (3) @(posedge CLK);
    chk(IRQ, 1);
    xfer(0, adr(`CH_DATA), 0);
    chk(q, 32'hA5);
    xfer(1, adr(`IDX_IRQ_STAT), 32'h01);
    repeat (3) @(posedge CLK);
    chk(IRQ, 0);
    $display("test receive interrupt done");
    xfer(1, adr(`IDX_TMR_LSB), 32'h03);
    xfer(1, adr(`IDX_TMR_CTRL), 32'h0B);
    for (int k = 0; k < 3; k++) begin
      TMR <= 1'b1;
      repeat (4) @(posedge CLK);
      TMR <= 1'b0;
      repeat (4) @(posedge CLK);
      xfer(0, adr(`IDX_IRQ_STAT), 0);
      chk(q, (k == 2) ? 32'h100 : 32'h0);
    end
    $display("test external timer done");
    chk(SER_TX[0], 1);
    xfer(1, adr(`CH_PRESC), 32'h01);
    for (int m = 1; m >= 0; m--) begin
      xfer(1, adr(`IDX_MODE8X), 32'(m));
      xfer(0, adr(`IDX_MODE8X), 0);
      chk(q, 32'(m));
      xfer(1, adr(`CH_DATA), 32'h55);
      for (n = 0; n < 200 && SER_TX[0] !== 1'b0; n++) @(posedge CLK);
      for (n = 0; n < 200 && SER_TX[0] === 1'b0; n++) @(posedge CLK);
      for (n = 0; n < 200 && SER_TX[0] === 1'b1; n++) @(posedge CLK);
      chk(n, m ? 32 : 64);
      repeat (700) @(posedge CLK);
    end
    $display("test prescaled transmit done");
    STRAP <= 1'b1;
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (5) @(posedge CLK);
    xfer(0, adr(`CH_PRESC), 0);
    chk(q, 0);
    xfer(0, adr(`CH_MCR), 0);
    chk(q, 32'h40);
    $display("test mid-run reset done");
    for (int s = 1; s >= 0; s--) begin
      SEL <= s[0];
      repeat (4) @(posedge CLK);
      CS_N <= 1'b0;
      RD_N <= 1'b0;
      WR_N <= s[0];
      pr = 0;
      pw = 0;
      repeat (8) begin
        @(posedge CLK);
        pr += RD_P;
        pw += WR_P;
      end
      chk(pr, s);
      chk(pw, 1 - s);
      CS_N <= 1'b1;
      RD_N <= 1'b1;
      WR_N <= 1'b1;
      repeat (6) @(posedge CLK);
    end
    $display("test bus style done");
    give_verdict;
  end
endmodule // tb_octal_uart_global_control
